// [inc/highway_pkg.sv]
// Constants and carrier types for the T1 system highway interface.
package highway_pkg;

  // Register map (word offsets on the plain register port).
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_RX_OFFSET = 4'h1;
  localparam logic [3:0] ADDR_TX_OFFSET = 4'h2;
  localparam logic [3:0] ADDR_TX_SLOT_MARK = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;

  // Configuration field positions.
  localparam int CFG_RX_CLK_RATE_LSB = 0;
  localparam int CFG_RX_DATA_RATE_LSB = 2;
  localparam int CFG_TX_CLK_RATE_LSB = 4;
  localparam int CFG_TX_DATA_RATE_LSB = 6;
  localparam int CFG_RX_EDGE = 8;
  localparam int CFG_TX_EDGE = 9;
  localparam int CFG_PHASE_LSB = 10;
  localparam int CFG_PIN_FUNC_LSB = 13;
  localparam int CFG_MARKER_WIDTH = 16;
  localparam int CFG_TX_MUX_EN = 17;
  localparam int CFG_TX_CLK_FROM_RX = 18;
  localparam int CFG_TX_SYNC_FROM_MF = 19;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

  // Frame geometry and timing.
  localparam int FRAME_BITS = 193;
  localparam int RX_FRONT_BITS = 7;
  localparam int RX_WRAP_BITS = 186;
  localparam int TX_WRAP_BITS = 200;
  localparam int TX_FRONT_BITS = 7;
  localparam int SLOTS = 24;
  localparam int FRAMES_PER_MF = 24;
  localparam int BASIC_BIT_NS = 648;
  localparam int CLK_PERIOD_NS = 25;
  localparam int BASIC_BIT_CYCLES = (BASIC_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] PIN_FUNC_MARKER = 3'b001;

  // Highway configuration as it travels inside the block.
  typedef struct packed {
    logic [1:0] clk_rate;
    logic [1:0] data_rate;
    logic edge_sel;
  } dir_cfg_t;

  typedef enum logic [1:0] {
    HW_IDLE,
    HW_RUN,
    HW_BAD_RATE
  } hw_state_t;

endpackage

// [hw/t1_highway.sv]
// Serial T1 system highway: receive and transmit framing, phases, markers and offsets.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module t1_highway
  import highway_pkg::*;
#(
  parameter int OFFSET_W = 11
)
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Highway pins.
  input wire logic rx_highway_clock,
  input wire logic tx_highway_clock,
  input wire logic rx_frame_sync_pulse,
  input wire logic tx_frame_sync_pulse,
  input wire logic tx_multiframe_sync_in,
  input wire logic tx_highway_data_in,
  input wire logic tx_highway_signaling_in,
  output logic rx_highway_data_out,
  output logic rx_highway_signaling_out,
  output logic rx_frame_marker,
  // Line side of the framer.
  input wire logic rx_line_data,
  input wire logic rx_line_signaling,
  output logic tx_line_data,
  output logic tx_line_valid
);

  if (OFFSET_W < 11 || OFFSET_W > 16)
  begin
    $error("OFFSET_W must be 11 to 16");
  end

  logic [31:0] config_q;
  logic [OFFSET_W-1:0] rx_offset_q;
  logic [OFFSET_W-1:0] tx_offset_q;
  logic [SLOTS-1:0] tx_slot_marker_pattern;
  logic [2:0] active_channel_phase;
  logic [2:0] rx_pin_function_code;
  logic marker_width_select;
  logic tx_slot_mux_enable;
  dir_cfg_t rx_cfg;
  dir_cfg_t tx_cfg;

  assign rx_cfg = '{config_q[CFG_RX_CLK_RATE_LSB +: 2], config_q[CFG_RX_DATA_RATE_LSB +: 2],
                    config_q[CFG_RX_EDGE]};
  assign tx_cfg = '{config_q[CFG_TX_CLK_RATE_LSB +: 2], config_q[CFG_TX_DATA_RATE_LSB +: 2],
                    config_q[CFG_TX_EDGE]};
  assign active_channel_phase = config_q[CFG_PHASE_LSB +: 3];
  assign rx_pin_function_code = config_q[CFG_PIN_FUNC_LSB +: 3];
  assign marker_width_select = config_q[CFG_MARKER_WIDTH];
  assign tx_slot_mux_enable = config_q[CFG_TX_MUX_EN];

  // Clocks per data bit as a log2 exponent; four when the clock is too slow.
  function automatic logic [2:0] ratio_log(input dir_cfg_t c);
    if (c.clk_rate < c.data_rate)
      ratio_log = 3'd4;
    else
      ratio_log = {1'b0, c.clk_rate - c.data_rate};
  endfunction

  // Clock slots in one frame for a given ratio exponent.
  function automatic logic [OFFSET_W-1:0] frame_len(input logic [2:0] r);
    frame_len = OFFSET_W'(FRAME_BITS << r);
  endfunction

  // Register writes.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      config_q <= CONFIG_RESET;
      rx_offset_q <= '0;
      tx_offset_q <= '0;
      tx_slot_marker_pattern <= '0;
    end
    else if (reg_write)
    begin
      if (reg_addr == ADDR_CONFIG)
        config_q <= reg_wdata;
      else if (reg_addr == ADDR_RX_OFFSET)
        rx_offset_q <= reg_wdata[OFFSET_W-1:0];
      else if (reg_addr == ADDR_TX_OFFSET)
        tx_offset_q <= reg_wdata[OFFSET_W-1:0];
      else if (reg_addr == ADDR_TX_SLOT_MARK)
        tx_slot_marker_pattern <= reg_wdata[SLOTS-1:0];
    end
  end

  // Pin synchronisers: two flops, then edge detection on the second stage.
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  logic [6:0] pin_s3_q;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end
    else
    begin
      pin_s1_q <= {tx_highway_clock, tx_highway_signaling_in, tx_highway_data_in, tx_multiframe_sync_in,
                   tx_frame_sync_pulse, rx_frame_sync_pulse, rx_highway_clock};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  logic rx_clk_s;
  logic tx_clk_s;
  logic rx_act;
  logic tx_act;
  logic tx_clk_from_rx;
  logic tx_clk_prev;
  assign rx_clk_s = pin_s2_q[0];
  assign tx_clk_from_rx = config_q[CFG_TX_CLK_FROM_RX];
  assign tx_clk_s = tx_clk_from_rx ? pin_s2_q[0] : pin_s2_q[6];
  assign tx_clk_prev = tx_clk_from_rx ? pin_s3_q[0] : pin_s3_q[6];
  // Active edge per direction: rising when the edge bit is clear.
  assign rx_act = rx_cfg.edge_sel ? (pin_s3_q[0] & ~rx_clk_s) : (~pin_s3_q[0] & rx_clk_s);
  assign tx_act = tx_cfg.edge_sel ? (tx_clk_prev & ~tx_clk_s) : (~tx_clk_prev & tx_clk_s);

  logic [2:0] rx_r;
  logic [2:0] tx_r;
  logic rx_ok;
  logic tx_ok;
  assign rx_r = ratio_log(rx_cfg);
  assign tx_r = ratio_log(tx_cfg);
  assign rx_ok = ~rx_r[2];
  assign tx_ok = ~tx_r[2];

  // Receive clock-slot counter, loaded with the offset on the sync edge unless in marker mode.
  logic [OFFSET_W-1:0] rx_cnt_q;
  logic rx_sync_prev_q;
  logic rx_marker_mode;
  assign rx_marker_mode = (rx_pin_function_code == PIN_FUNC_MARKER);
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rx_cnt_q <= '0;
      rx_sync_prev_q <= 1'b0;
    end
    else if (rx_act && rx_ok)
    begin
      rx_sync_prev_q <= pin_s2_q[1];
      if (pin_s2_q[1] && !rx_sync_prev_q && !rx_marker_mode)
        rx_cnt_q <= rx_offset_q;
      else if (rx_cnt_q >= frame_len(rx_r) - 1'b1)
        rx_cnt_q <= '0;
      else
        rx_cnt_q <= rx_cnt_q + 1'b1;
    end
  end

  // Phase within a bit, and whether this is the active phase.
  logic [2:0] rx_phase;
  logic [2:0] tx_phase;
  assign rx_phase = 3'(rx_cnt_q & OFFSET_W'((1 << rx_r[1:0]) - 1));
  logic rx_phase_ok;
  logic tx_phase_ok;
  assign rx_phase_ok = (rx_phase == (active_channel_phase & 3'((1 << rx_r[1:0]) - 1)));

  // Receive outputs: data and signaling in the active phase only, otherwise cleared; the frame marker ignores the phase.
  logic [4:0] rfm_cnt_q;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rx_highway_data_out <= 1'b0;
      rx_highway_signaling_out <= 1'b0;
      rx_frame_marker <= 1'b0;
      rfm_cnt_q <= '0;
    end
    else if (!rx_ok)
    begin
      rx_highway_data_out <= 1'b0;
      rx_highway_signaling_out <= 1'b0;
      rx_frame_marker <= 1'b0;
    end
    else
    begin
      if (rx_act)
      begin
        rx_highway_data_out <= rx_phase_ok ? rx_line_data : 1'b0;
        rx_highway_signaling_out <= rx_phase_ok ? rx_line_signaling : 1'b0;
      end
      if (rx_act && rx_marker_mode && rx_cnt_q == rx_offset_q)
      begin
        rx_frame_marker <= 1'b1;
        rfm_cnt_q <= marker_width_select ? 5'd1 : 5'(BASIC_BIT_CYCLES);
      end
      else if (rfm_cnt_q > 5'd1)
        rfm_cnt_q <= rfm_cnt_q - 5'd1;
      else if (rfm_cnt_q == 5'd1 && (!marker_width_select || rx_act))
      begin
        rfm_cnt_q <= '0;
        rx_frame_marker <= 1'b0;
      end
    end
  end

  // Transmit counter from sync or multiframe sync.
  logic [OFFSET_W-1:0] tx_cnt_q;
  logic tx_sync_prev_q;
  logic tx_sync;
  logic [4:0] tx_frame_q;
  assign tx_sync = config_q[CFG_TX_SYNC_FROM_MF] ? pin_s2_q[3] : pin_s2_q[2];
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      tx_cnt_q <= '0;
      tx_sync_prev_q <= 1'b0;
      tx_frame_q <= '0;
    end
    else if (tx_act && tx_ok)
    begin
      tx_sync_prev_q <= tx_sync;
      if (tx_sync && !tx_sync_prev_q)
      begin
        tx_cnt_q <= tx_offset_q;
        if (config_q[CFG_TX_SYNC_FROM_MF])
          tx_frame_q <= '0;
      end
      else if (tx_cnt_q >= frame_len(tx_r) - 1'b1)
      begin
        tx_cnt_q <= '0;
        tx_frame_q <= (tx_frame_q == 5'(FRAMES_PER_MF - 1)) ? 5'd0 : tx_frame_q + 5'd1;
      end
      else
        tx_cnt_q <= tx_cnt_q + 1'b1;
    end
  end

  assign tx_phase = 3'(tx_cnt_q & OFFSET_W'((1 << tx_r[1:0]) - 1));
  assign tx_phase_ok = (tx_phase == (active_channel_phase & 3'((1 << tx_r[1:0]) - 1)));

  // Time slot of the current transmit bit; slot 0 holds the framing bit.
  logic [OFFSET_W-1:0] tx_bit;
  logic [4:0] tx_slot;
  logic slot_marked;
  assign tx_bit = tx_cnt_q >> tx_r[1:0];
  assign tx_slot = (tx_bit == '0) ? 5'd0 : 5'((tx_bit - 1'b1) >> 3);
  assign slot_marked = tx_slot_marker_pattern[tx_slot];

  // Transmit sampling.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      tx_line_data <= 1'b0;
      tx_line_valid <= 1'b0;
    end
    else
    begin
      tx_line_valid <= 1'b0;
      if (tx_act && tx_ok && tx_phase_ok)
      begin
        if (tx_slot_mux_enable && slot_marked)
        begin
          // Signaling is only taken in the last frame of the multiframe.
          if (tx_frame_q == 5'(FRAMES_PER_MF - 1))
          begin
            tx_line_data <= pin_s2_q[5];
            tx_line_valid <= 1'b1;
          end
        end
        else if (!tx_slot_mux_enable && !slot_marked && tx_slot != 5'd0)
          tx_line_valid <= 1'b0;
        else
        begin
          tx_line_data <= pin_s2_q[4];
          tx_line_valid <= 1'b1;
        end
      end
    end
  end

  // Register reads, answered one cycle after the strobe.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      reg_rdata <= '0;
    else if (reg_read)
    begin
      if (reg_addr == ADDR_CONFIG)
        reg_rdata <= config_q;
      else if (reg_addr == ADDR_RX_OFFSET)
        reg_rdata <= 32'(rx_offset_q);
      else if (reg_addr == ADDR_TX_OFFSET)
        reg_rdata <= 32'(tx_offset_q);
      else if (reg_addr == ADDR_TX_SLOT_MARK)
        reg_rdata <= 32'(tx_slot_marker_pattern);
      else if (reg_addr == ADDR_STATUS)
        reg_rdata <= {13'h0000, tx_ok, rx_ok, 5'(tx_frame_q), tx_cnt_q[5:0], rx_cnt_q[5:0]};
      else
        reg_rdata <= 32'h0000_0000;
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule
`default_nettype wire

// [tb/highway_properties.sv]
// Assertions on the highway block ports.
`timescale 1ns/1ps
`default_nettype none
module highway_properties
  import highway_pkg::*;
(
  // Clock and register port.
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  // Highway outputs.
  input wire logic rx_highway_data_out,
  input wire logic rx_highway_signaling_out,
  input wire logic rx_frame_marker,
  input wire logic tx_line_valid
);
  logic [19:0] cfg_q;
  logic [5:0] age_q;
  logic [5:0] len_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Shadow configuration, its age and the marker length.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      cfg_q <= '0;
    else if (reg_write && reg_addr == ADDR_CONFIG)
      cfg_q <= reg_wdata[19:0];
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset || (reg_write && reg_addr == ADDR_CONFIG))
      age_q <= '0;
    else if (age_q != 6'h3F)
      age_q <= age_q + 6'h01;
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset || !rx_frame_marker)
      len_q <= '0;
    else
      len_q <= len_q + 6'h01;
  end
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data not idle");
  a_unmapped_zero: assert property (reg_read && reg_addr > ADDR_STATUS |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_mark_readback: assert property ((reg_write && reg_addr == ADDR_TX_SLOT_MARK) ##1 !reg_write ##1
    (reg_read && reg_addr == ADDR_TX_SLOT_MARK) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("slot marker readback wrong");
  a_reset_quiet: assert property (disable iff (1'b0) $past(reset) |->
    !rx_frame_marker && !tx_line_valid && !rx_highway_data_out)
    else $error("outputs active after reset");
  a_valid_spaced: assert property (tx_line_valid |=> !tx_line_valid [*5])
    else $error("bit valid too close");
  a_marker_width: assert property (rx_frame_marker |-> len_q < 6'h1A)
    else $error("marker too wide");
  a_marker_mode: assert property (age_q == 6'h3F && cfg_q[15:13] != PIN_FUNC_MARKER |-> !rx_frame_marker)
    else $error("marker outside marker mode");
  a_rx_rate_idle: assert property (age_q == 6'h3F && cfg_q[1:0] < cfg_q[3:2] |->
    !rx_highway_data_out && !rx_highway_signaling_out)
    else $error("rx active with low clock");
  a_tx_rate_idle: assert property (age_q == 6'h3F && cfg_q[5:4] < cfg_q[7:6] |-> !tx_line_valid)
    else $error("tx active with low clock");
endmodule
`default_nettype wire

// [tb/highway_far_end.sv]
// Behavioural backplane that clocks and frames the highway.
`timescale 1ns/1ps
`default_nettype none
module highway_far_end
  import highway_pkg::*;
(
  // Frame length selector.
  input wire logic [1:0] ratio_code,
  // Clocks, syncs and transmit lines.
  output logic rx_highway_clock,
  output logic tx_highway_clock,
  output logic rx_frame_sync_pulse,
  output logic tx_frame_sync_pulse,
  output logic tx_multiframe_sync_in,
  output logic tx_highway_data_in,
  output logic tx_highway_signaling_in
);
  int bit_q = 0;
  int frame_q = 0;
  // Transmit clock is the receive clock delayed by 20 ns.
  assign #20 tx_highway_clock = rx_highway_clock;
  initial
  begin
    {rx_highway_clock, rx_frame_sync_pulse, tx_frame_sync_pulse, tx_multiframe_sync_in} = 4'h0;
    tx_highway_data_in = 1'b1;
    tx_highway_signaling_in = 1'b0;
    #37;
    forever #100 rx_highway_clock = ~rx_highway_clock;
  end
  always @(posedge rx_highway_clock)
  begin
    bit_q = (bit_q + 1) % (FRAME_BITS << ratio_code);
    if (bit_q == 0)
      frame_q = (frame_q + 1) % FRAMES_PER_MF;
    tx_highway_signaling_in = (frame_q == FRAMES_PER_MF - 1) ? 1'b0 : bit_q[0];
    if (bit_q == 0)
      fork
        pulse();
      join_none
  end
  task automatic pulse();
    {rx_frame_sync_pulse, tx_frame_sync_pulse, tx_multiframe_sync_in} = {2'h3, frame_q == 0};
    #(BASIC_BIT_NS);
    {rx_frame_sync_pulse, tx_frame_sync_pulse, tx_multiframe_sync_in} = 3'h0;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Register-driven bench for the highway block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import highway_pkg::*;
  logic sys_clk, reset, reg_write, reg_read, rx_line_data, rx_line_signaling;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [1:0] ratio_code;
  wire logic [31:0] reg_rdata;
  wire logic rx_highway_clock, tx_highway_clock, rx_frame_sync_pulse, tx_frame_sync_pulse, tx_multiframe_sync_in;
  wire logic tx_highway_data_in, tx_highway_signaling_in, rx_highway_data_out, rx_highway_signaling_out;
  wire logic rx_frame_marker, tx_line_data, tx_line_valid;
  int mismatches = 0;
  int tests_run = 0;
  int w, d, s, v, bad;
  longint t0, t1, ph[2];
  logic [31:0] modes [3] = '{32'h0, 32'h2_0000, 32'hC_0000};
  t1_highway DUT (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .rx_highway_clock, .tx_highway_clock, .rx_frame_sync_pulse, .tx_frame_sync_pulse, .tx_multiframe_sync_in,
    .tx_highway_data_in, .tx_highway_signaling_in, .rx_highway_data_out, .rx_highway_signaling_out,
    .rx_frame_marker, .rx_line_data, .rx_line_signaling, .tx_line_data, .tx_line_valid);
  highway_far_end far (.ratio_code, .rx_highway_clock, .tx_highway_clock, .rx_frame_sync_pulse,
    .tx_frame_sync_pulse, .tx_multiframe_sync_in, .tx_highway_data_in, .tx_highway_signaling_in);
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic tally_and_finish(input bit late);
    if (late)
      mismatches++;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] x);
    reg_addr <= a;
    reg_wdata <= x;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(posedge sys_clk);
    check(n, e, reg_rdata);
  endtask
  task automatic marker(output longint rise, output int width);
    int n;
    n = 0;
    while (rx_frame_marker !== 1'b1 && n < 9000)
    begin
      @(posedge sys_clk);
      n++;
    end
    rise = $time;
    width = 0;
    while (rx_frame_marker === 1'b1 && width < 40)
    begin
      @(posedge sys_clk);
      width++;
    end
    if (n >= 9000)
      tally_and_finish(1'b1);
  endtask
  task automatic watch();
    d = 0;
    s = 0;
    v = 0;
    bad = 0;
    repeat (3200)
    begin
      @(posedge sys_clk);
      d += int'(rx_highway_data_out === 1'b1);
      s += int'(rx_highway_signaling_out === 1'b1);
      v += int'(tx_line_valid === 1'b1);
      bad += int'(tx_line_valid === 1'b1 && tx_line_data !== 1'b1);
    end
  endtask
  initial
  begin
    reset = 1'b1;
    {reg_write, reg_read, rx_line_data, rx_line_signaling} = 4'h3;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    ratio_code = 2'h0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    for (int a = 0; a < 4; a++)
      rd(4'(a), 32'h0, "reset value");
    rd(4'hF, 32'h0, "unmapped");
    wr(ADDR_TX_SLOT_MARK, 32'h00A5_5AC3);
    rd(ADDR_TX_SLOT_MARK, 32'h00A5_5AC3, "slot marker");
    wr(ADDR_TX_OFFSET, 32'(3 - 2 + TX_FRONT_BITS));
    rd(ADDR_TX_OFFSET, 32'h8, "tx offset");
    for (int i = 0; i < 4; i++)
    begin
      ratio_code <= 2'(i / 2);
      wr(ADDR_RX_OFFSET, 32'(12 + RX_FRONT_BITS * (1 << (i / 2))));
      wr(ADDR_CONFIG, 32'(i / 2) * 32'h11 | 32'(i % 2) * 32'h1_0100 | 32'h2000);
      marker(t0, w);
      marker(t0, w);
      marker(t1, w);
      check("marker width", (i % 2) ? 32'h8 : 32'(BASIC_BIT_CYCLES), 32'(w));
      check("frame period", 32'((FRAME_BITS << (i / 2)) * 200), 32'(t1 - t0));
      if (i < 2)
        ph[i] = t1 % 200;
    end
    check("edge phase", 32'h64, 32'((ph[1] - ph[0] + 200) % 200));
    ratio_code <= 2'h0;
    wr(ADDR_TX_SLOT_MARK, 32'h0);
    wr(ADDR_CONFIG, 32'h44);
    watch();
    check("idle at low clock", 32'h0, 32'(d + s + v));
    for (int j = 0; j < 3; j++)
    begin
      wr(ADDR_CONFIG, modes[j]);
      watch();
      check("rx payload", 32'h1, 32'(d > 0));
      check("rx signaling", 32'h1, 32'(s > 0));
      check("tx bits", 32'h1, 32'(v > 0));
      check("tx bit value", 32'h0, 32'(bad));
    end
    tally_and_finish(1'b0);
  end
endmodule
bind t1_highway highway_properties u_props (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .rx_highway_data_out, .rx_highway_signaling_out, .rx_frame_marker, .tx_line_valid);
`default_nettype wire
